// ===== design/scroll_idle_cmd.sv
// Scroll start pointer and idle mode command interpreter
// ****************************************************************
// Overview of operation
// - Opcode 37h starts a scroll pointer load and the next parameter bytes form the pointer.
// - The pointer and the top and scroll area sizes together map panel rows to lines; the bottom area size is not used.
// - The pointer arrives as two parameters, upper byte first, and names the line under the top area.
// - A new pointer only takes effect at the start of the next panel scan.
// - The pointer applies for both refresh orders and the mapping direction follows that bit.
// - Opcode 38h, with no parameter, leaves idle state and restores full colour.
// - With idle cleared the full 18-bit colour, 262,144 colours, reaches the panel.
// - Opcode 38h outside idle state changes nothing except aborting an unfinished pointer load.
// - Opcode 39h, with no parameter, enters idle state.
// - In idle state only the top bit of red, green and blue sets the colour, giving eight colours.
// - The vertical refresh order bit selects the panel's vertical scan direction.
// ****************************************************************
`timescale 1ns/1ps
module scroll_idle_cmd (
  input wire logic clk,
  input wire logic nrst,
  input wire logic soft_reset,
  input wire scroll_idle_pkg::bus_pins_t bus_pins,
  input wire logic vertical_refresh_order,
  input wire scroll_idle_pkg::scroll_geom_t geom,
  input wire logic frame_start,
  input wire logic [15:0] scan_row,
  input wire scroll_idle_pkg::pixel_t pixel_in,
  input wire logic pixel_in_valid,
  output logic [15:0] scroll_line_pointer,
  output logic idle_active,
  output logic [15:0] frame_line,
  output scroll_idle_pkg::pixel_t pixel_out,
  output logic pixel_out_valid
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [scroll_idle_pkg::SYNC_STAGES-1:0] dc_sync;
    logic [scroll_idle_pkg::SYNC_STAGES:0] wr_sync;
    logic [scroll_idle_pkg::SYNC_STAGES-1:0][7:0] d_sync;
    scroll_idle_pkg::cmd_state_t fsm;
    logic [7:0] vsp_upper;
    logic [15:0] vsp_pending;
    logic pending;
    logic [15:0] vsp_active;
    logic idle;
    logic [15:0] line;
  } cmd_regs_t;

  cmd_regs_t st_reg;
  cmd_regs_t st_next;
  logic wr_rise;
  logic is_cmd;
  logic is_par;
  logic [7:0] byte_in;
  logic [15:0] row;
  logic [16:0] area_end;
  logic [16:0] offs;
  logic in_scroll;

  // ****************************************************************
  // Byte capture and decode
  // ****************************************************************
  // Strobe sampled twice, then a third copy for the edge; first stages feed nothing else
  // The stages hold the inverted strobe, so the end of the low phase is a one to zero step
  // Reset leaves them at zero, the idle high strobe, so no false byte follows reset
  assign wr_rise = ~st_reg.wr_sync[1] & st_reg.wr_sync[0];
  assign is_cmd = wr_rise & ~st_reg.dc_sync[0];
  assign is_par = wr_rise & st_reg.dc_sync[0];
  assign byte_in = st_reg.d_sync[0];

  // Row actually scanned, reversed when the refresh order bit is set
  assign row = vertical_refresh_order ? 16'(scroll_idle_pkg::PANEL_LINES - 16'h0001 - scan_row)
    : scan_row;
  assign area_end = {1'b0, geom.top_fixed} + {1'b0, geom.scroll_area};
  assign in_scroll = (row >= geom.top_fixed) && ({1'b0, row} < area_end);
  // No guard for a pointer inside a fixed area; a single wrap is enough otherwise
  assign offs = {1'b0, st_reg.vsp_active} + {1'b0, row} - {1'b0, geom.top_fixed};

  always_comb begin
    st_next = st_reg;
    st_next.dc_sync = {bus_pins.data_command_select, st_reg.dc_sync[1]};
    st_next.wr_sync = {~bus_pins.write_strobe_n, st_reg.wr_sync[2:1]};
    st_next.d_sync = {bus_pins.data, st_reg.d_sync[1]};
    // Any opcode aborts an unfinished pointer load
    if (is_cmd) begin
      st_next.fsm = scroll_idle_pkg::CMD_WAIT;
      case (byte_in)
        scroll_idle_pkg::OPC_SCROLL_START: begin
          st_next.fsm = scroll_idle_pkg::VSP_UPPER;
        end
        scroll_idle_pkg::OPC_IDLE_EXIT: begin
          st_next.idle = 1'b0;
        end
        scroll_idle_pkg::OPC_IDLE_ENTER: begin
          st_next.idle = 1'b1;
        end
        default: begin
          st_next.fsm = scroll_idle_pkg::CMD_WAIT;
        end
      endcase
    end else if (is_par) begin
      case (st_reg.fsm)
        scroll_idle_pkg::VSP_UPPER: begin
          st_next.vsp_upper = byte_in;
          st_next.fsm = scroll_idle_pkg::VSP_LOWER;
        end
        scroll_idle_pkg::VSP_LOWER: begin
          st_next.vsp_pending = {st_reg.vsp_upper, byte_in};
          st_next.pending = 1'b1;
          st_next.fsm = scroll_idle_pkg::CMD_WAIT;
        end
        default: begin
          st_next.fsm = scroll_idle_pkg::CMD_WAIT;
        end
      endcase
    end
    // A pointer completed in the same cycle as the scan start waits for the next scan
    if (frame_start && st_reg.pending) begin
      st_next.vsp_active = st_reg.vsp_pending;
      st_next.pending = st_next.pending & is_par & (st_reg.fsm == scroll_idle_pkg::VSP_LOWER);
    end
    if (in_scroll) begin
      st_next.line = (offs >= area_end) ? 16'(offs - {1'b0, geom.scroll_area})
        : offs[15:0];
    end else begin
      st_next.line = row;
    end
    if (soft_reset) begin
      st_next.fsm = scroll_idle_pkg::CMD_WAIT;
      st_next.vsp_pending = scroll_idle_pkg::VSP_RESET;
      st_next.pending = 1'b0;
      st_next.vsp_active = scroll_idle_pkg::VSP_RESET;
      st_next.idle = scroll_idle_pkg::IDLE_RESET;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign scroll_line_pointer = st_reg.vsp_active;
  assign idle_active = st_reg.idle;
  assign frame_line = st_reg.line;

  idle_color_reduce u_reduce (
    .clk(clk),
    .nrst(nrst),
    .idle(st_reg.idle),
    .pixel_in(pixel_in),
    .pixel_in_valid(pixel_in_valid),
    .pixel_out(pixel_out),
    .pixel_out_valid(pixel_out_valid)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_open_load;
    is_cmd && byte_in == 8'h37 && !soft_reset;
  endsequence

  // One byte per step; the host may pause for any time between the two bytes
  sequence s_upper_byte;
    st_reg.fsm == scroll_idle_pkg::VSP_UPPER && is_par && !soft_reset;
  endsequence

  sequence s_lower_byte;
    st_reg.fsm == scroll_idle_pkg::VSP_LOWER && is_par && !soft_reset;
  endsequence

  a_load_opcode: assert property (s_open_load |=> st_reg.fsm == scroll_idle_pkg::VSP_UPPER)
    else $error("scroll start opcode not decoded");

  a_upper_first: assert property (
    s_upper_byte |=> st_reg.fsm == scroll_idle_pkg::VSP_LOWER
      && st_reg.vsp_upper == $past(byte_in))
    else $error("upper pointer byte not held");

  a_pointer_pairing: assert property (
    s_lower_byte |=> st_reg.pending && st_reg.vsp_pending[7:0] == $past(byte_in)
      && st_reg.vsp_pending[15:8] == $past(st_reg.vsp_upper))
    else $error("pointer bytes not paired upper first");

  a_stray_param: assert property (
    is_par && st_reg.fsm == scroll_idle_pkg::CMD_WAIT && !soft_reset && !frame_start
      |=> $stable(st_reg.vsp_pending) && $stable(st_reg.pending)
        && st_reg.fsm == scroll_idle_pkg::CMD_WAIT)
    else $error("parameter outside a pointer load was taken");

  a_apply_at_scan: assert property (
    frame_start && st_reg.pending && !soft_reset |=> st_reg.vsp_active == $past(st_reg.vsp_pending))
    else $error("pending pointer not applied at scan start");

  a_hold_mid_frame: assert property (!frame_start && !soft_reset |=> $stable(st_reg.vsp_active))
    else $error("pointer changed mid frame");

  a_idle_leave: assert property (is_cmd && byte_in == 8'h38 && !soft_reset |=> !st_reg.idle)
    else $error("idle not left");

  a_idle_enter: assert property (is_cmd && byte_in == 8'h39 && !soft_reset |=> st_reg.idle)
    else $error("idle not entered");

  a_exit_noop: assert property (
    !st_reg.idle && is_cmd && byte_in == 8'h38 && !soft_reset && !frame_start
      |=> !st_reg.idle && $stable(st_reg.vsp_active) && st_reg.pending == $past(st_reg.pending))
    else $error("idle exit outside idle changed state");

  a_fixed_rows: assert property (!in_scroll |=> frame_line == $past(row))
    else $error("fixed area row remapped");

  // Only meaningful while the host keeps the pointer inside the scroll area
  a_scroll_window: assert property (
    in_scroll && st_reg.vsp_active >= geom.top_fixed && {1'b0, st_reg.vsp_active} < area_end
      |=> frame_line >= $past(geom.top_fixed) && {1'b0, frame_line} < $past(area_end))
    else $error("scrolled row left the scroll area");

  a_soft_clear: assert property (soft_reset |=> st_reg.vsp_active == 16'h0000 && !st_reg.idle)
    else $error("soft reset did not clear state");
endmodule

// ===== design/scroll_idle_pkg.sv
// Constants and carrier types shared by the scroll-start and idle-mode command logic
package scroll_idle_pkg;
  localparam logic [7:0] OPC_SCROLL_START = 8'h37;
  localparam logic [7:0] OPC_IDLE_EXIT = 8'h38;
  localparam logic [7:0] OPC_IDLE_ENTER = 8'h39;
  localparam int LINE_W = 16;
  localparam int COLOR_W = 6;
  localparam logic [15:0] PANEL_LINES = 16'h01E0;
  localparam logic [15:0] VSP_RESET = 16'h0000;
  localparam logic IDLE_RESET = 1'b0;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    CMD_WAIT,
    VSP_UPPER,
    VSP_LOWER
  } cmd_state_t;

  // Command bus pins as they arrive from the host
  typedef struct packed {
    logic data_command_select;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [7:0] data;
  } bus_pins_t;

  // Area sizes programmed by the scroll-area definition command
  typedef struct packed {
    logic [15:0] top_fixed;
    logic [15:0] scroll_area;
    logic [15:0] bottom_fixed;
  } scroll_geom_t;

  typedef struct packed {
    logic [COLOR_W-1:0] red;
    logic [COLOR_W-1:0] green;
    logic [COLOR_W-1:0] blue;
  } pixel_t;
endpackage

// ===== design/idle_color_reduce.sv
// Pixel colour path: full colour or eight-colour reduction in idle state
`timescale 1ns/1ps
module idle_color_reduce (
  input wire logic clk,
  input wire logic nrst,
  input wire logic idle,
  input wire scroll_idle_pkg::pixel_t pixel_in,
  input wire logic pixel_in_valid,
  output scroll_idle_pkg::pixel_t pixel_out,
  output logic pixel_out_valid
);
  typedef struct packed {
    scroll_idle_pkg::pixel_t pix;
    logic valid;
  } reduce_state_t;

  reduce_state_t st_reg;
  reduce_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.valid = pixel_in_valid;
    if (pixel_in_valid) begin
      if (idle) begin
        // Top bit fans out so the eight colours span black to full white
        st_next.pix.red = {scroll_idle_pkg::COLOR_W{pixel_in.red[scroll_idle_pkg::COLOR_W-1]}};
        st_next.pix.green = {scroll_idle_pkg::COLOR_W{pixel_in.green[scroll_idle_pkg::COLOR_W-1]}};
        st_next.pix.blue = {scroll_idle_pkg::COLOR_W{pixel_in.blue[scroll_idle_pkg::COLOR_W-1]}};
      end else begin
        st_next.pix = pixel_in;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pixel_out = st_reg.pix;
  assign pixel_out_valid = st_reg.valid;

  a_idle_eight_color: assert property (@(posedge clk) disable iff (!nrst)
    idle && pixel_in_valid |=> pixel_out.red[0] == pixel_out.red[5]
      && pixel_out.green[2] == $past(pixel_in.green[5])
      && pixel_out.blue[4] == $past(pixel_in.blue[5]))
    else $error("idle pixel not reduced to top bits");

  a_full_color_pass: assert property (@(posedge clk) disable iff (!nrst)
    !idle && pixel_in_valid |=> pixel_out == $past(pixel_in) && pixel_out_valid)
    else $error("full colour pixel altered");
endmodule

// ===== test/host_model.sv
// Host model driving the command bus pins
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output scroll_idle_pkg::bus_pins_t bus_pins
);
  initial begin
    bus_pins = '{data_command_select: 1'b0, write_strobe_n: 1'b1, read_strobe_n: 1'b1,
      data: 8'h00};
  end
  // Strobe phases of four clocks clear the two-stage synchroniser with margin
  task automatic send(input logic dc, input logic [7:0] b);
    @(negedge clk);
    bus_pins.data_command_select = dc;
    bus_pins.data = b;
    bus_pins.write_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    bus_pins.write_strobe_n = 1'b1;
    repeat (4) @(negedge clk);
    bus_pins.data = ~b;
    repeat (2) @(negedge clk);
  endtask
endmodule

// ===== test/tb_scroll_idle_cmd.sv
// Self-checking bench for the scroll start and idle mode commands
`timescale 1ns/1ps
`define chk(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_scroll_idle_cmd;
  logic clk;
  logic nrst;
  logic soft_reset;
  logic vertical_refresh_order;
  logic frame_start;
  logic pixel_in_valid;
  logic [15:0] scan_row;
  logic [15:0] scroll_line_pointer;
  logic [15:0] frame_line;
  logic idle_active;
  logic pixel_out_valid;
  scroll_idle_pkg::bus_pins_t bus_pins;
  scroll_idle_pkg::scroll_geom_t geom;
  scroll_idle_pkg::pixel_t pixel_in;
  scroll_idle_pkg::pixel_t pixel_out;
  int miscompares = 0;
  int n_checks = 0;
  host_model host_model_i (.clk(clk), .bus_pins(bus_pins));
  scroll_idle_cmd scroll_idle_cmd_i (.clk(clk), .nrst(nrst), .soft_reset(soft_reset),
    .bus_pins(bus_pins), .vertical_refresh_order(vertical_refresh_order), .geom(geom),
    .frame_start(frame_start), .scan_row(scan_row), .pixel_in(pixel_in),
    .pixel_in_valid(pixel_in_valid), .scroll_line_pointer(scroll_line_pointer),
    .idle_active(idle_active), .frame_line(frame_line), .pixel_out(pixel_out),
    .pixel_out_valid(pixel_out_valid));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic pix(input scroll_idle_pkg::pixel_t p, input scroll_idle_pkg::pixel_t e);
    @(negedge clk);
    pixel_in = p;
    pixel_in_valid = 1'b1;
    @(negedge clk);
    pixel_in_valid = 1'b0;
    `chk(pixel_out, e)
    `chk(pixel_out_valid, 1'b1)
  endtask
  task automatic frame;
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    @(negedge clk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_idle;
    host_model_i.send(1'b0, scroll_idle_pkg::OPC_IDLE_ENTER);
    `chk(idle_active, 1'b1)
    pix(18'h296A5, 18'h3F03F);
    host_model_i.send(1'b0, scroll_idle_pkg::OPC_IDLE_EXIT);
    `chk(idle_active, 1'b0)
    pix(18'h296A5, 18'h296A5);
    host_model_i.send(1'b0, scroll_idle_pkg::OPC_IDLE_EXIT);
    `chk(idle_active, 1'b0)
  endtask
  task automatic t_scroll;
    host_model_i.send(1'b0, scroll_idle_pkg::OPC_SCROLL_START);
    host_model_i.send(1'b1, 8'h01);
    host_model_i.send(1'b1, 8'h23);
    `chk(scroll_line_pointer, 16'h0000)
    frame();
    `chk(scroll_line_pointer, 16'h0123)
    // A load cut short by another opcode must leave the pointer alone
    host_model_i.send(1'b0, scroll_idle_pkg::OPC_SCROLL_START);
    host_model_i.send(1'b1, 8'h05);
    host_model_i.send(1'b0, scroll_idle_pkg::OPC_IDLE_ENTER);
    // A stray parameter would complete the load if the abort failed
    host_model_i.send(1'b1, 8'h77);
    frame();
    `chk(scroll_line_pointer, 16'h0123)
    `chk(idle_active, 1'b1)
  endtask
  task automatic t_map;
    logic [16:0] cases [4];
    logic [15:0] want [4];
    cases = '{17'h00014, 17'h10014, 17'h00005, 17'h10005};
    want = '{16'h012D, 16'h0118, 16'h0005, 16'h01DA};
    geom = '{top_fixed: 16'h000A, scroll_area: 16'h01CC, bottom_fixed: 16'h000A};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      vertical_refresh_order = cases[i][16];
      scan_row = cases[i][15:0];
      @(negedge clk);
      `chk(frame_line, want[i])
    end
  endtask
  task automatic t_soft;
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    @(negedge clk);
    `chk(scroll_line_pointer, 16'h0000)
    `chk(idle_active, 1'b0)
  endtask
  initial begin
    #(25 * 5000);
    miscompares++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    soft_reset = 1'b0;
    vertical_refresh_order = 1'b0;
    frame_start = 1'b0;
    pixel_in_valid = 1'b0;
    scan_row = 16'h0000;
    pixel_in = 18'h00000;
    geom = '{top_fixed: 16'h0000, scroll_area: 16'h01E0, bottom_fixed: 16'h0000};
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    `chk(scroll_line_pointer, scroll_idle_pkg::VSP_RESET)
    `chk(idle_active, scroll_idle_pkg::IDLE_RESET)
    t_idle();
    t_scroll();
    t_map();
    t_soft();
    close_out();
  end
endmodule
